// ==== core/pwm_source_select_dac_ctrl.sv ====
// pwm output control of the fine resolution channels and dac control of comparator units
`timescale 1ns/10ps
`default_nettype none
// How it works
// RL1: four fine channels, each with a fine edge delay in 150 ps steps.
// RL2: each channel has selectors 0 and 1 giving set and clear pulses.
// RL3: with both paths enabled, selector 0 pulses beat selector 1 pulses.
// RL4: software may rewrite the selector assignment field at any time.
// RL5: one path enabled: assignment 1 picks selector 1, 0 picks selector 0.
// RL6: selector 1 assigned and both selectors pulse together drops selector 1 pulse.
// RL7: feeding timers space selector events a cycle apart or halt selector 0.
// RL8: three comparator units, each with dac, comparator and control logic.
// RL9: each unit has static and slope modes; mode zero is static.
// RL10: static mode converts one software value from either value register.
// RL11: static mode value writes raise no conversion trigger.
// RL12: slope modes generate patterns and trigger without that defect.
// RL13: software applies a static value by clearing then setting the run bit.
// RL14: output goes high on set, low on clear, and holds between pulses.
module pwm_source_select_dac_ctrl
  import pwm_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata_q,
  input  wire logic [NUM_CHAN-1:0] s0_set,
  input  wire logic [NUM_CHAN-1:0] s0_clr,
  input  wire logic [NUM_CHAN-1:0] s1_set,
  input  wire logic [NUM_CHAN-1:0] s1_clr,
  output logic      [NUM_CHAN-1:0] pwm_q,
  output logic      [FINE_W-1:0]   fine_delay_q [NUM_CHAN],
  input  wire logic [NUM_UNIT-1:0] cmp_in,
  output logic      [NUM_UNIT-1:0] cmp_q,
  output logic      [DAC_W-1:0]    dac_data_q [NUM_UNIT],
  output logic      [NUM_UNIT-1:0] dac_trig_q
);
  logic [15:0]         chan_ctrl_q, chan_ctrl_d;
  logic [FINE_W-1:0]   fine_delay_d [NUM_CHAN];
  logic [NUM_UNIT-1:0] run_q, run_d;
  dac_mode_e           mode_q [NUM_UNIT];
  dac_mode_e           mode_d [NUM_UNIT];
  logic [NUM_UNIT-1:0] vsel_q, vsel_d;
  logic [NUM_UNIT-1:0] dir_q, dir_d;
  logic [DAC_W-1:0]    val1_q [NUM_UNIT];
  logic [DAC_W-1:0]    val1_d [NUM_UNIT];
  logic [DAC_W-1:0]    val2_q [NUM_UNIT];
  logic [DAC_W-1:0]    val2_d [NUM_UNIT];
  logic [DAC_W-1:0]    dac_d  [NUM_UNIT];
  logic [NUM_UNIT-1:0] trig_d;
  logic [NUM_UNIT-1:0] run_rise;
  logic [31:0]         rdata_d;

  // channel array
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    fine_res_channel u_chan ( // RL1 RL2
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .hr_en                 (chan_ctrl_q[c*CH_FIELD_W + CH_HR_BIT]),
      .lr_en                 (chan_ctrl_q[c*CH_FIELD_W + CH_LR_BIT]),
      .selector_assign_field (chan_ctrl_q[c*CH_FIELD_W + CH_ASSIGN_BIT]),
      .s0_set                (s0_set[c]),
      .s0_clr                (s0_clr[c]),
      .s1_set                (s1_set[c]),
      .s1_clr                (s1_clr[c]),
      .pwm_q                 (pwm_q[c])
    );
  end

  // register writes
  always_comb begin
    chan_ctrl_d = chan_ctrl_q;
    run_d       = run_q;
    vsel_d      = vsel_q;
    for (int c = 0; c < NUM_CHAN; c++) begin
      fine_delay_d[c] = fine_delay_q[c];
    end
    for (int u = 0; u < NUM_UNIT; u++) begin
      mode_d[u] = mode_q[u];
      val1_d[u] = val1_q[u];
      val2_d[u] = val2_q[u];
    end
    if (wr) begin
      if (addr == ADDR_CHAN_CTRL) begin
        chan_ctrl_d = wdata[15:0]; // RL4
      end
      if (addr == ADDR_FINE_DLY) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          // steps beyond one clock period saturate
          if (wdata[c*FINE_LANE_W +: FINE_W] > FINE_W'(FINE_STEPS)) begin
            fine_delay_d[c] = FINE_W'(FINE_STEPS); // RL1
          end else begin
            fine_delay_d[c] = wdata[c*FINE_LANE_W +: FINE_W]; // RL1
          end
        end
      end
      if (addr == ADDR_RUN_SET) begin
        run_d = run_q | wdata[NUM_UNIT-1:0]; // RL13
      end
      if (addr == ADDR_RUN_CLR) begin
        run_d = run_q & ~wdata[NUM_UNIT-1:0]; // RL13
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        if (addr[7:4] == UNIT_BASE_HI + 4'(u)) begin
          if (addr[3:0] == UNIT_CTRL) begin
            mode_d[u] = dac_mode_e'(wdata[MODE_LSB +: MODE_W]); // RL9
            vsel_d[u] = wdata[VSEL_BIT];
          end
          if (addr[3:0] == UNIT_VAL1) begin
            val1_d[u] = wdata[DAC_W-1:0]; // RL10
          end
          if (addr[3:0] == UNIT_VAL2) begin
            val2_d[u] = wdata[DAC_W-1:0]; // RL10
          end
        end
      end
    end
  end

  // dac sequencing per comparator unit
  always_comb begin
    for (int u = 0; u < NUM_UNIT; u++) begin // RL8
      run_rise[u] = run_d[u] & ~run_q[u];
      dac_d[u]    = dac_data_q[u];
      dir_d[u]    = dir_q[u];
      trig_d[u]   = 1'b0;
      if (mode_q[u] == MODE_STATIC) begin
        // value writes alone never convert; only a run restart does
        if (run_rise[u]) begin // RL11 RL13
          dac_d[u]  = vsel_q[u] ? val2_q[u] : val1_q[u]; // RL10
          trig_d[u] = 1'b1;
        end
      end else if (run_rise[u]) begin
        dac_d[u]  = (mode_q[u] == MODE_RAMP_DOWN) ? val2_q[u] : val1_q[u];
        dir_d[u]  = 1'b1;
        trig_d[u] = 1'b1; // RL12
      end else if (run_q[u]) begin
        trig_d[u] = 1'b1; // RL12
        unique case (mode_q[u])
          MODE_RAMP_UP: begin
            dac_d[u] = (dac_data_q[u] >= val2_q[u]) ? val1_q[u] : dac_data_q[u] + 10'h001;
          end
          MODE_RAMP_DOWN: begin
            dac_d[u] = (dac_data_q[u] <= val1_q[u]) ? val2_q[u] : dac_data_q[u] - 10'h001;
          end
          MODE_TRIANGLE: begin
            if (dir_q[u]) begin
              dir_d[u] = (dac_data_q[u] + 10'h001 < val2_q[u]);
              dac_d[u] = (dac_data_q[u] >= val2_q[u]) ? dac_data_q[u] - 10'h001
                                                      : dac_data_q[u] + 10'h001;
            end else begin
              dir_d[u] = !(dac_data_q[u] - 10'h001 > val1_q[u]);
              dac_d[u] = (dac_data_q[u] <= val1_q[u]) ? dac_data_q[u] + 10'h001
                                                      : dac_data_q[u] - 10'h001;
            end
          end
          MODE_STATIC: begin
            dac_d[u] = dac_data_q[u];
          end
        endcase
      end
    end
  end

  // read port, data one cycle after the strobe
  always_comb begin
    rdata_d = RDATA_RST;
    if (rd) begin
      if (addr == ADDR_CHAN_CTRL) begin
        rdata_d = {16'h0000, chan_ctrl_q};
      end
      if (addr == ADDR_CHAN_STAT) begin
        rdata_d = {28'h000_0000, pwm_q};
      end
      if (addr == ADDR_FINE_DLY) begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          rdata_d[c*FINE_LANE_W +: FINE_W] = fine_delay_q[c];
        end
      end
      if (addr == ADDR_RUN_STAT) begin
        rdata_d = {29'h0000_0000, run_q};
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        if (addr[7:4] == UNIT_BASE_HI + 4'(u)) begin
          if (addr[3:0] == UNIT_CTRL) begin
            rdata_d[MODE_LSB +: MODE_W] = mode_q[u];
            rdata_d[VSEL_BIT]           = vsel_q[u];
          end
          if (addr[3:0] == UNIT_VAL1) begin
            rdata_d[DAC_W-1:0] = val1_q[u];
          end
          if (addr[3:0] == UNIT_VAL2) begin
            rdata_d[DAC_W-1:0] = val2_q[u];
          end
          if (addr[3:0] == UNIT_STAT) begin
            rdata_d[DAC_W-1:0]    = dac_data_q[u];
            rdata_d[STAT_RUN_BIT] = run_q[u];
            rdata_d[STAT_CMP_BIT] = cmp_q[u];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan_ctrl_q <= CHAN_CTRL_RST;
      run_q       <= '0;
      vsel_q      <= '0;
      dir_q       <= '0;
      dac_trig_q  <= '0;
      cmp_q       <= '0;
      rdata_q     <= RDATA_RST;
      for (int c = 0; c < NUM_CHAN; c++) begin
        fine_delay_q[c] <= FINE_DLY_RST;
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        mode_q[u]     <= MODE_STATIC;
        val1_q[u]     <= DAC_VAL_RST;
        val2_q[u]     <= DAC_VAL_RST;
        dac_data_q[u] <= DAC_VAL_RST;
      end
    end else begin
      chan_ctrl_q <= chan_ctrl_d;
      run_q       <= run_d;
      vsel_q      <= vsel_d;
      dir_q       <= dir_d;
      dac_trig_q  <= trig_d;
      cmp_q       <= cmp_in;
      rdata_q     <= rdata_d;
      for (int c = 0; c < NUM_CHAN; c++) begin
        fine_delay_q[c] <= fine_delay_d[c];
      end
      for (int u = 0; u < NUM_UNIT; u++) begin
        mode_q[u]     <= mode_d[u];
        val1_q[u]     <= val1_d[u];
        val2_q[u]     <= val2_d[u];
        dac_data_q[u] <= dac_d[u];
      end
    end
  end

  // checks on every comparator unit
  for (genvar u = 0; u < NUM_UNIT; u++) begin : g_unit_chk
    sequence s_static_run;
      run_q[u] && mode_q[u] == MODE_STATIC;
    endsequence
    sequence s_val_write;
      wr && addr[7:4] == UNIT_BASE_HI + 4'(u)
         && (addr[3:0] == UNIT_VAL1 || addr[3:0] == UNIT_VAL2);
    endsequence
    sequence s_run_start;
      !run_q[u] && wr && addr == ADDR_RUN_SET && wdata[u];
    endsequence

    chk_static_no_trig: assert property (@(posedge clk) disable iff (sys_rst) // RL11
      s_static_run and s_val_write |=> !dac_trig_q[u] && $stable(dac_data_q[u]))
      else $error("static value write converted");
    chk_restart_convert: assert property (@(posedge clk) disable iff (sys_rst) // RL13
      s_run_start and (mode_q[u] == MODE_STATIC && !vsel_q[u])
        |=> dac_trig_q[u] && dac_data_q[u] == $past(val1_q[u]))
      else $error("run restart did not convert primary value");
    chk_static_hold: assert property (@(posedge clk) disable iff (sys_rst) // RL10
      s_static_run ##1 s_static_run |-> $stable(dac_data_q[u]) && !dac_trig_q[u])
      else $error("static dac value moved");
    chk_slope_trig: assert property (@(posedge clk) disable iff (sys_rst) // RL12
      (run_q[u] && mode_q[u] != MODE_STATIC) |=> dac_trig_q[u])
      else $error("slope mode missed trigger");
    chk_ramp_step: assert property (@(posedge clk) disable iff (sys_rst) // RL9
      (run_q[u] && run_d[u] && mode_q[u] == MODE_RAMP_UP && dac_data_q[u] < val2_q[u])
        |=> dac_data_q[u] == $past(dac_data_q[u]) + 10'h001)
      else $error("ramp did not step up by one");
    chk_slope_start: assert property (@(posedge clk) disable iff (sys_rst) // RL12
      s_run_start and (mode_q[u] != MODE_STATIC) |=> dac_trig_q[u])
      else $error("slope start missed trigger");
    chk_run_clear: assert property (@(posedge clk) disable iff (sys_rst) // RL13
      (wr && addr == ADDR_RUN_CLR && wdata[u]) |=> !run_q[u])
      else $error("run bit not cleared");
    chk_mode_write: assert property (@(posedge clk) disable iff (sys_rst) // RL9
      (wr && addr == {UNIT_BASE_HI + 4'(u), UNIT_CTRL})
        |=> mode_q[u] == $past(wdata[MODE_LSB +: MODE_W]))
      else $error("unit mode not taken");
  end

  // checks on the register port and shared outputs
  chk_fine_saturate: assert property (@(posedge clk) disable iff (sys_rst) // RL1
    (wr && addr == ADDR_FINE_DLY && wdata[FINE_W-1:0] > FINE_W'(FINE_STEPS))
      |=> fine_delay_q[0] == FINE_W'(FINE_STEPS))
    else $error("fine delay did not saturate");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !rd |=> rdata_q == RDATA_RST)
    else $error("read data not zero without strobe");
  chk_cmp_copy: assert property (@(posedge clk) disable iff (sys_rst) // RL8
    !sys_rst |=> cmp_q == $past(cmp_in))
    else $error("comparator copy wrong or late");
  chk_assign_write: assert property (@(posedge clk) disable iff (sys_rst) // RL4
    (wr && addr == ADDR_CHAN_CTRL) |=> chan_ctrl_q == $past(wdata[15:0]))
    else $error("assignment field not taken");
  chk_read_latency: assert property (@(posedge clk) disable iff (sys_rst)
    (rd && addr == ADDR_RUN_STAT) |=> rdata_q == {29'h0000_0000, $past(run_q)})
    else $error("read data wrong or late");
endmodule : pwm_source_select_dac_ctrl
`default_nettype wire

// ==== core/pwm_ctrl_pkg.sv ====
// constants, register map and mode encodings for the pwm output and dac control block
package pwm_ctrl_pkg;
  localparam int NUM_CHAN      = 4;
  localparam int NUM_UNIT      = 3;
  localparam int DAC_W         = 10;
  localparam int ADDR_W        = 8;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int FINE_STEP_PS  = 150;
  localparam int FINE_STEPS    = CLK_PERIOD_PS / FINE_STEP_PS;
  localparam int FINE_W        = 7;
  localparam int FINE_LANE_W   = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CHAN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHAN_STAT = 8'h04;
  localparam logic [7:0] ADDR_FINE_DLY  = 8'h08;
  localparam logic [7:0] ADDR_RUN_SET   = 8'h10;
  localparam logic [7:0] ADDR_RUN_CLR   = 8'h14;
  localparam logic [7:0] ADDR_RUN_STAT  = 8'h18;
  localparam logic [3:0] UNIT_BASE_HI   = 4'h2;
  localparam logic [3:0] UNIT_CTRL      = 4'h0;
  localparam logic [3:0] UNIT_VAL1      = 4'h4;
  localparam logic [3:0] UNIT_VAL2      = 4'h8;
  localparam logic [3:0] UNIT_STAT      = 4'hC;
  // field positions
  localparam int CH_FIELD_W    = 4;
  localparam int CH_HR_BIT     = 0;
  localparam int CH_LR_BIT     = 1;
  localparam int CH_ASSIGN_BIT = 2;
  localparam int MODE_LSB      = 0;
  localparam int MODE_W        = 2;
  localparam int VSEL_BIT      = 4;
  localparam int STAT_RUN_BIT  = 16;
  localparam int STAT_CMP_BIT  = 17;
  // reset values
  localparam logic [15:0]      CHAN_CTRL_RST = 16'h0000;
  localparam logic [DAC_W-1:0] DAC_VAL_RST   = 10'h000;
  localparam logic [FINE_W-1:0] FINE_DLY_RST = 7'h00;
  localparam logic [31:0]      RDATA_RST     = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_STATIC    = 2'h0,
    MODE_RAMP_UP   = 2'h1,
    MODE_RAMP_DOWN = 2'h2,
    MODE_TRIANGLE  = 2'h3
  } dac_mode_e;
endpackage : pwm_ctrl_pkg

// ==== core/fine_res_channel.sv ====
// one fine resolution channel: two source selectors merged into one pwm level
`timescale 1ns/10ps
`default_nettype none
module fine_res_channel (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic hr_en,
  input  wire logic lr_en,
  input  wire logic selector_assign_field,
  input  wire logic s0_set,
  input  wire logic s0_clr,
  input  wire logic s1_set,
  input  wire logic s1_clr,
  output logic      pwm_q
);
  logic pwm_d;
  logic set_ok;
  logic clr_ok;
  logic s0_any;

  always_comb begin
    s0_any = s0_set | s0_clr;
    set_ok = 1'b0;
    clr_ok = 1'b0;
    if (hr_en && lr_en) begin
      // selector 0 pulses win over selector 1 pulses
      set_ok = s0_set | (s1_set & ~s0_any); // RL3
      clr_ok = s0_clr | (s1_clr & ~s0_any); // RL3
    end else if (hr_en || lr_en) begin
      if (selector_assign_field) begin
        // selector 1 pulse lost when selector 0 fires in the same cycle
        set_ok = s1_set & ~s0_any; // RL6
        clr_ok = s1_clr & ~s0_any; // RL6
      end else begin
        set_ok = s0_set; // RL5
        clr_ok = s0_clr; // RL5
      end
    end
    // clear wins over set within one cycle
    pwm_d = clr_ok ? 1'b0 : (set_ok ? 1'b1 : pwm_q); // RL14
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= pwm_d;
    end
  end

  sequence s_one_path;
    hr_en ^ lr_en;
  endsequence

  chk_defect_drop: assert property (@(posedge clk) disable iff (sys_rst) // RL6
    s_one_path and (selector_assign_field && s0_any) |=> $stable(pwm_q))
    else $error("selector 1 pulse was not dropped on collision");
  chk_sel0_priority: assert property (@(posedge clk) disable iff (sys_rst) // RL3
    (hr_en && lr_en && s0_set && !s0_clr) |=> pwm_q)
    else $error("selector 0 set lost priority");
  chk_assign_route: assert property (@(posedge clk) disable iff (sys_rst) // RL5
    s_one_path and (!selector_assign_field && s0_clr) |=> !pwm_q)
    else $error("selector 0 clear not honoured");
  chk_level_hold: assert property (@(posedge clk) disable iff (sys_rst) // RL14
    (!s0_set && !s0_clr && !s1_set && !s1_clr) |=> $stable(pwm_q))
    else $error("pwm level moved with no pulse");
endmodule : fine_res_channel
`default_nettype wire

// ==== verif/timer_slice_model.sv ====
// timer slices feeding the selector set/clear inputs of the fine channels
`timescale 1ns/10ps
`default_nettype none
module timer_slice_model
  import pwm_ctrl_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                cmd_v,
  input  wire logic [1:0]          cmd_ch,
  input  wire logic [3:0]          cmd_ev,
  input  wire logic                spaced,
  output logic      [NUM_CHAN-1:0] s0_set,
  output logic      [NUM_CHAN-1:0] s0_clr,
  output logic      [NUM_CHAN-1:0] s1_set,
  output logic      [NUM_CHAN-1:0] s1_clr
);
  // event bits: 0 s0 set, 1 s0 clear, 2 s1 set, 3 s1 clear
  logic [3:0] ev_d, ev_q, held_d, held_q;
  logic [1:0] ch_d, ch_q, hch_d, hch_q;
  always_comb begin
    ev_d   = 4'h0;
    held_d = 4'h0;
    ch_d   = cmd_ch;
    hch_d  = cmd_ch;
    if (held_q != 4'h0) begin
      ev_d = held_q;
      ch_d = hch_q;
    end else if (cmd_v) begin
      ev_d = cmd_ev;
      if (spaced && (|cmd_ev[1:0]) && (|cmd_ev[3:2])) begin
        ev_d   = {2'b00, cmd_ev[1:0]};
        held_d = {cmd_ev[3:2], 2'b00};
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_q   <= 4'h0;
      held_q <= 4'h0;
      ch_q   <= 2'h0;
      hch_q  <= 2'h0;
    end else begin
      ev_q   <= ev_d;
      held_q <= held_d;
      ch_q   <= ch_d;
      hch_q  <= hch_d;
    end
  end
  always_comb begin
    s0_set       = '0;
    s0_clr       = '0;
    s1_set       = '0;
    s1_clr       = '0;
    s0_set[ch_q] = ev_q[0];
    s0_clr[ch_q] = ev_q[1];
    s1_set[ch_q] = ev_q[2];
    s1_clr[ch_q] = ev_q[3];
  end
endmodule : timer_slice_model
`default_nettype wire

// ==== verif/pwm_source_select_dac_ctrl_bench.sv ====
// self-checking bench for the pwm output and dac control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t mismatch got %0h exp %0h", $time, (a), (e)); end end
module pwm_source_select_dac_ctrl_bench
  import pwm_ctrl_pkg::*;
;
  logic                clk = 0, sys_rst = 1, wr = 0, rd = 0;
  logic [ADDR_W-1:0]   addr = '0;
  logic [31:0]         wdata = '0, rdata_q, rv;
  logic [NUM_CHAN-1:0] s0_set, s0_clr, s1_set, s1_clr, pwm_q;
  logic [FINE_W-1:0]   fine_delay_q [NUM_CHAN];
  logic [NUM_UNIT-1:0] cmp_in = '0, cmp_q, dac_trig_q;
  logic [DAC_W-1:0]    dac_data_q [NUM_UNIT];
  logic                cmd_v = 0, spaced = 0;
  logic [1:0]          cmd_ch = '0;
  logic [3:0]          cmd_ev = '0;
  int                  error_cnt = 0, samples_checked = 0, n;

  pwm_source_select_dac_ctrl dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .s0_set(s0_set), .s0_clr(s0_clr), .s1_set(s1_set),
    .s1_clr(s1_clr), .pwm_q(pwm_q), .fine_delay_q(fine_delay_q), .cmp_in(cmp_in),
    .cmp_q(cmp_q), .dac_data_q(dac_data_q), .dac_trig_q(dac_trig_q));
  timer_slice_model part_u (.clk(clk), .sys_rst(sys_rst), .cmd_v(cmd_v), .cmd_ch(cmd_ch),
    .cmd_ev(cmd_ev), .spaced(spaced), .s0_set(s0_set), .s0_clr(s0_clr), .s1_set(s1_set),
    .s1_clr(s1_clr));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata_q;
  endtask : rd_reg

  task automatic chan_cfg(input int c, input logic [2:0] b);
    wr_reg(ADDR_CHAN_CTRL, {29'h0, b} << (4 * c));
  endtask : chan_cfg

  task automatic pulse(input int c, input logic [3:0] ev, input logic sp);
    @(posedge clk);
    cmd_ch <= 2'(c);
    cmd_ev <= ev;
    spaced <= sp;
    cmd_v  <= 1'b1;
    @(posedge clk);
    cmd_v  <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse

  task automatic trig_n(input int u, output int k);
    k = 0;
    repeat (5) begin
      #1;
      if (dac_trig_q[u] === 1'b1) k++;
      @(posedge clk);
    end
    #1;
  endtask : trig_n

  task automatic test_single;
    chan_cfg(0, 3'b001);
    pulse(0, 4'b0001, 0); `CHK(pwm_q[0], 1'b1)
    pulse(0, 4'b1000, 0); `CHK(pwm_q[0], 1'b1)
    chan_cfg(0, 3'b101);
    pulse(0, 4'b1000, 0); `CHK(pwm_q[0], 1'b0)
    pulse(0, 4'b0001, 0); `CHK(pwm_q[0], 1'b0)
    pulse(0, 4'b0100, 0); `CHK(pwm_q[0], 1'b1)
    rd_reg(ADDR_CHAN_STAT, rv); `CHK(rv, 32'h0000_0001)
    pulse(0, 4'b1001, 0); `CHK(pwm_q[0], 1'b1)
    pulse(0, 4'b1001, 1); `CHK(pwm_q[0], 1'b0)
    $display("test single path done");
  endtask : test_single

  task automatic test_both;
    chan_cfg(2, 3'b011);
    pulse(2, 4'b0101, 0); `CHK(pwm_q[2], 1'b1)
    pulse(2, 4'b0110, 0); `CHK(pwm_q[2], 1'b0)
    chan_cfg(2, 3'b111);
    pulse(2, 4'b1001, 0); `CHK(pwm_q[2], 1'b1)
    pulse(2, 4'b0011, 0); `CHK(pwm_q[2], 1'b0)
    $display("test both paths done");
  endtask : test_both

  task automatic test_dac;
    wr_reg(8'h30, 32'h0000_0000);
    wr_reg(8'h34, 32'h0000_0155);
    wr_reg(ADDR_RUN_SET, 32'h0000_0002);
    trig_n(1, n); `CHK(n, 1)
    `CHK(dac_data_q[1], 10'h155)
    rd_reg(ADDR_RUN_STAT, rv); `CHK(rv, 32'h0000_0002)
    wr_reg(8'h34, 32'h0000_00AA);
    trig_n(1, n); `CHK(n, 0)
    `CHK(dac_data_q[1], 10'h155)
    wr_reg(ADDR_RUN_CLR, 32'h0000_0002);
    wr_reg(ADDR_RUN_SET, 32'h0000_0002);
    trig_n(1, n); `CHK(n, 1)
    `CHK(dac_data_q[1], 10'h0AA)
    wr_reg(8'h30, 32'h0000_0010);
    wr_reg(8'h38, 32'h0000_03FF);
    wr_reg(ADDR_RUN_CLR, 32'h0000_0002);
    wr_reg(ADDR_RUN_SET, 32'h0000_0002);
    trig_n(1, n);
    `CHK(dac_data_q[1], 10'h3FF)
    rd_reg(8'h3C, rv); `CHK(rv, 32'h0001_03FF)
    wr_reg(8'h34, 32'h0000_0005);
    wr_reg(8'h38, 32'h0000_0009);
    for (int m = 1; m < 4; m++) begin
      wr_reg(ADDR_RUN_CLR, 32'h0000_0002);
      wr_reg(8'h30, 32'(m));
      wr_reg(ADDR_RUN_SET, 32'h0000_0002);
      trig_n(1, n); `CHK(n >= 4, 1'b1)
    end
    $display("test dac done");
  endtask : test_dac

  task automatic test_misc;
    rd_reg(8'hF0, rv); `CHK(rv, 32'h0000_0000)
    wr_reg(ADDR_FINE_DLY, 32'h0000_107F);
    #1 `CHK(fine_delay_q[0], 7'h42)
    `CHK(fine_delay_q[1], 7'h10)
    @(posedge clk);
    cmp_in <= 3'b101;
    repeat (3) @(posedge clk);
    #1 `CHK(cmp_q, 3'b101)
    $display("test misc done");
  endtask : test_misc

  task automatic test_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1 `CHK(dac_data_q[1], 10'h000)
    `CHK(dac_trig_q, 3'b000)
    `CHK(fine_delay_q[0], 7'h00)
    `CHK(cmp_q, 3'b000)
    rd_reg(ADDR_RUN_STAT, rv); `CHK(rv, 32'h0000_0000)
    $display("test reset done");
  endtask : test_reset

  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #200us;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(ADDR_CHAN_STAT, rv); `CHK(rv, 32'h0000_0000)
    test_single();
    test_both();
    test_dac();
    test_misc();
    test_reset();
    stop_test();
  end
endmodule : pwm_source_select_dac_ctrl_bench
`default_nettype wire
